// [common/ldc_pkg.sv]
package ldc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SETTLE_MS = 10;
  localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
  localparam int SLOPE_UNIT_US = 10;
  localparam int SLOPE_UNIT_CYC = CLK_HZ / 1_000_000 * SLOPE_UNIT_US;
  localparam int MEAS_BASE_MS = 525;
  localparam int MEAS_BASE_CYC = CLK_HZ / 1000 * MEAS_BASE_MS;
  localparam int MEAS_WIN_US = 1000;
  localparam int MEAS_WIN_CYC = CLK_HZ / 1_000_000 * MEAS_WIN_US;
  localparam logic [3:0] KEY_DARK_LVL = 4'h4;
  localparam logic [19:0] DUTY_CNT_MAX = 20'hfffff;
  localparam logic [3:0] DIV_STEPS = 4'h8;
  // register word indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_MCFG = 6'h02;
  localparam logic [5:0] IDX_MLVL = 6'h03;
  localparam logic [5:0] IDX_MSLP = 6'h0a;
  localparam logic [5:0] IDX_RSLP = 6'h0b;
  localparam logic [5:0] IDX_ACFG = 6'h0c;
  localparam logic [5:0] IDX_ABRT = 6'h0d;
  localparam logic [5:0] IDX_STAT = 6'h0e;
  localparam logic [5:0] IDX_RCFG = 6'h20;
  localparam logic [5:0] IDX_RLVL0 = 6'h21;
  localparam logic [5:0] IDX_RLVL1 = 6'h22;
  localparam logic [5:0] IDX_RLVL2 = 6'h23;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MCFG = 8'h02;
  localparam logic [7:0] RST_LVL = 8'h00;
  localparam logic [7:0] RST_SLP = 8'h00;
  localparam logic [7:0] RST_ACFG = 8'h00;
  localparam logic [7:0] RST_RCFG = 8'h00;
  typedef struct packed {
    logic [4:0] rsv;
    logic kb_en;
    logic alc_en;
    logic srst;
  } ldc_ctrl_t;
  typedef struct packed {
    logic cai_en;
    logic [3:0] rsv;
    logic comb;
    logic mhd;
    logic pol;
  } ldc_mcfg_t;
  typedef struct packed {
    logic sync;
    logic curve;
    logic [3:0] rsv;
    logic [1:0] per;
  } ldc_acfg_t;
  typedef struct packed {
    logic slope_en;
    logic [2:0] on;
    logic [1:0] rsv;
    logic pol;
    logic gate;
  } ldc_rcfg_t;
  typedef enum logic [1:0] {
    C_OFF = 2'b00,
    C_SET = 2'b01,
    C_RUN = 2'b11,
    C_HOLD = 2'b10
  } ldc_cai_st_t;
endpackage

// [sim/ldc_host_model.sv]
`timescale 1ns/1ps
module ldc_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [15:0] hi_n,
  input wire logic [15:0] per_n,
  input wire logic [7:0] sample,
  input wire logic start,
  output logic duty,
  output logic valid,
  output logic [7:0] data
);
  logic [15:0] cnt;
  logic [1:0] dly;
  // pwm source, period kept inside the accepted band
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      duty <= 1'b0;
    end else begin
      cnt <= (!run || cnt >= per_n - 16'h1) ? 16'h0 : cnt + 16'h1;
      duty <= run && (cnt < hi_n);
    end
  end
  // adc answers each start two cycles later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dly <= '0;
    end else begin
      dly <= {dly[0], start};
    end
  end
  assign valid = dly[1];
  // undriven outside the strobe, so show the inverse
  assign data = valid ? sample : ~sample;
endmodule

// [sim/led_dimming_control_test.sv]
`timescale 1ns/1ps
module led_dimming_control_test import ldc_pkg::*;;
  logic clk, rst, psel, pen, pwr, indicator_gate_input, run, als_v, dty;
  logic [7:0] paddr, als_d, smp, rl, gl, bl, ml;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, bias, start, kp, men, e;
  logic [2:0] en;
  logic [15:0] hi_n, per_n;
  int errors, n_tests;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // short counts keep the run brief
  ldc_top #(.SETTLE_N(50), .MEAS_BASE_N(200), .MEAS_WIN_N(20)) dut_u (
    .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INDICATOR_GATE_INPUT_IN(indicator_gate_input), .DUTY_IN(dty),
    .ALS_DATA(als_d), .ALS_VALID(als_v), .RGB_EN(en), .R_LVL(rl),
    .G_LVL(gl), .B_LVL(bl), .MAIN_EN(men), .MAIN_LVL(ml),
    .BIAS_EN(bias), .ALS_START(start), .KEYPAD_ON(kp)
  );

  ldc_host_model host_u (
    .clk(clk), .rst(rst), .run(run), .hi_n(hi_n), .per_n(per_n),
    .sample(smp), .start(start), .duty(dty), .valid(als_v), .data(als_d)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask

  task rd(input logic [5:0] i, input logic [31:0] x, input logic xe);
    xfer(1'b0, i, 8'h00);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask

  task indicator_gate_input_hold(input logic v, input logic [2:0] x);
    indicator_gate_input <= v;
    cyc(4000); // gate level held 80 us
    check({29'h0, en}, {29'h0, x});
  endtask

  task amb(input logic [7:0] s, input logic [7:0] cfg,
           input logic [11:0] xa, input logic [7:0] xm,
           input logic xk, input int xb);
    int cnt;
    cnt = 0;
    smp <= s;
    wr(IDX_ACFG, cfg);
    cyc(1800);
    rd(IDX_ABRT, {20'h0, xa}, 1'b0);
    check({24'h0, ml}, {24'h0, xm});
    check({31'h0, kp}, {31'h0, xk});
    repeat (200) begin
      @(posedge clk);
      cnt += bias;
    end
    check(cnt, xb);
  endtask

  initial begin
    cyc(95000);
    errors++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    indicator_gate_input = 1'b0;
    run = 1'b0;
    smp = 8'h40;
    hi_n = 16'd2500;
    per_n = 16'd3334;
    errors = 0;
    n_tests = 0;
    cyc(5);
    rst <= 1'b0;
    rd(IDX_CTRL, 32'h0, 1'b0);
    rd(IDX_MCFG, 32'h2, 1'b0);
    rd(IDX_RCFG, 32'h0, 1'b0);
    rd(6'h01, 32'h0, 1'b1);
    wr(IDX_ABRT, 8'hff);
    check({31'h0, e}, 32'h0);
    wr(IDX_RLVL0, 8'h10);
    wr(IDX_RLVL0 + 6'h1, 8'h20);
    wr(IDX_RLVL2, 8'h30);
    wr(IDX_RCFG, 8'h50);
    cyc(3);
    check({29'h0, en}, 32'h5);
    check({8'h0, rl, gl, bl}, 32'h0010ff30);
    // slow ramp: four steps of 500 cycles
    wr(IDX_RSLP, 8'h00);
    wr(IDX_RCFG, 8'hd0);
    wr(IDX_RLVL0, 8'h14);
    cyc(20);
    check({31'h0, rl <= 8'h11}, 32'h1);
    cyc(2600);
    check({24'h0, rl}, 32'h14);
    wr(IDX_RCFG, 8'h50);
    wr(IDX_RLVL0, 8'h10);
    cyc(3);
    check({24'h0, rl}, 32'h10);
    wr(IDX_RCFG, 8'h01);
    indicator_gate_input_hold(1'b1, 3'b111);
    wr(IDX_RLVL0, 8'h40);
    cyc(3);
    check({24'h0, rl}, 32'h40);
    indicator_gate_input_hold(1'b0, 3'b000);
    wr(IDX_RCFG, 8'h03);
    indicator_gate_input_hold(1'b0, 3'b111);
    indicator_gate_input_hold(1'b1, 3'b000);
    indicator_gate_input <= 1'b0;
    wr(IDX_MLVL, 8'h80);
    cyc(3);
    check({23'h0, men, ml}, 32'h180);
    // slow main ramp would miss the duty level in time
    wr(IDX_MSLP, 8'h81);
    run <= 1'b1;
    wr(IDX_MCFG, 8'h83);
    cyc(20);
    check({24'h0, ml}, 32'h80);
    cyc(100);
    rd(IDX_STAT, 32'h580, 1'b0);
    wr(IDX_MCFG, 8'h02);
    wr(IDX_MCFG, 8'h81);
    cyc(47000);
    check({31'h0, ml > 8'd179 && ml < 8'd200}, 32'h1);
    wr(IDX_MLVL, 8'h7f);
    cyc(3);
    check({31'h0, ml > 8'd179 && ml < 8'd200}, 32'h1);
    check({21'h0, en, rl}, 32'h740);
    wr(IDX_MCFG, 8'h87);
    cyc(3);
    check({31'h0, ml > 8'd87 && ml < 8'd100}, 32'h1);
    wr(IDX_MSLP, 8'h00);
    wr(IDX_MCFG, 8'h02);
    run <= 1'b0;
    wr(IDX_CTRL, 8'h06);
    amb(8'h40, 8'h80, 12'hc40, 8'hcf, 1'b0, 20);
    amb(8'h02, 8'h80, 12'h202, 8'h2f, 1'b1, 20);
    amb(8'h40, 8'h40, 12'h440, 8'h4f, 1'b0, 200);
    wr(IDX_MCFG, 8'h05);
    wr(IDX_CTRL, 8'h01);
    cyc(3);
    rd(IDX_CTRL, 32'h0, 1'b0);
    rd(IDX_MCFG, 32'h2, 1'b0);
    wrap_up();
  end
endmodule

// [src/ldc_top.sv]
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - each colour current has 256 steps of 0.1 mA, set per channel
// - colours switched by gate input level or host on bits; host default
// - host on bits act per colour; gate input switches all three together
// - gate polarity bit 0 means active high, 1 means active low
// - gate only enables; active gives programmed current, inactive zero
// - host-only colour control ramps at the programmed colour slope rate
// - colour slope enable low makes current changes immediate
// - duty maps linearly to main current, 0 to 25.6 mA
// - standalone duty dimming overrides host and ambient brightness
// - duty input accepts 100 Hz to 15 kHz; source stays in range
// - duty dimming starts when its enable bit is set by host
// - main ramp is suppressed while duty dimming is enabled
// - previous main current held about 10 ms before duty current applies
// - host dimming bit still set after settle keeps previous current unless combined mode is set
// - combined mode: last host or ambient current is full scale at 100%
// - ambient samples averaged; brightness readable by host
// - ambient enable hands main brightness to ambient path; host default
// - separate ambient and keypad enable bits; keypad is a logic level
// - bias on with ambient enable; sync bit limits it to measurements
// - sixteen ambient levels, log conversion or bypass by curve bit
// - duty dimming acts only on the main white group
module ldc_top import ldc_pkg::*; #(
  parameter int SETTLE_N = SETTLE_CYC,
  parameter int MEAS_BASE_N = MEAS_BASE_CYC,
  parameter int MEAS_WIN_N = MEAS_WIN_CYC
)(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic INDICATOR_GATE_INPUT_IN,
  input wire logic DUTY_IN,
  input wire logic [7:0] ALS_DATA,
  input wire logic ALS_VALID,
  output logic [2:0] RGB_EN,
  output logic [7:0] R_LVL,
  output logic [7:0] G_LVL,
  output logic [7:0] B_LVL,
  output logic MAIN_EN,
  output logic [7:0] MAIN_LVL,
  output logic BIAS_EN,
  output logic ALS_START,
  output logic KEYPAD_ON
);
  ldc_ctrl_t ctrl_q;
  ldc_mcfg_t mcfg_q;
  ldc_acfg_t acfg_q;
  ldc_rcfg_t rcfg_q;
  logic [7:0] mlvl_q, mslp_q, rslp_q;
  logic [7:0] rlvl_q [3];
  logic srst_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic mapped;
  logic [5:0] idx;
  logic wr_en;
  ldc_cai_st_t st_q;
  logic [19:0] set_cnt_q;
  logic [8:0] snap_q;
  logic [7:0] avg;
  logic [9:0] acc_q;
  logic [7:0] als_avg_q;
  logic [3:0] als_lvl_q;
  logic [8:0] tgt [4];
  logic ramp [4];
  logic [6:0] rate [4];
  logic [8:0] v_q [4];
  logic en_q [4];
  logic [7:0] lvl_q [4];
  logic tick_q;
  logic [8:0] pre_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // apb slave: zero wait states, answer in first access cycle
  assign idx = PADDR[7:2];
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

  always_comb begin
    mapped = 1'b1;
    rd_d = 32'h0;
    case (idx)
      IDX_CTRL: rd_d = {24'h0, ctrl_q[7:1], 1'b0};
      IDX_MCFG: rd_d = {24'h0, mcfg_q};
      IDX_MLVL: rd_d = {24'h0, mlvl_q};
      IDX_MSLP: rd_d = {24'h0, mslp_q};
      IDX_RSLP: rd_d = {24'h0, rslp_q};
      IDX_ACFG: rd_d = {24'h0, acfg_q};
      IDX_ABRT: rd_d = {20'h0, als_lvl_q, als_avg_q};
      IDX_STAT: rd_d = {21'h0, st_q, MAIN_EN, MAIN_LVL};
      IDX_RCFG: rd_d = {24'h0, rcfg_q};
      IDX_RLVL0, IDX_RLVL1, IDX_RLVL2:
        rd_d = {24'h0, rlvl_q[2'(idx - IDX_RLVL0)]};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= PSEL && !PENABLE;
      pslverr_q <= PSEL && !PENABLE && !mapped;
      prdata_q <= (PSEL && !PENABLE && !PWRITE) ? rd_d : 32'h0;
    end
  end
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // self-clearing soft reset returns every writable register to its reset value; ABRT and STAT are left alone
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) srst_q <= 1'b0;
    else srst_q <= wr_en && idx == IDX_CTRL && PWDATA[0];
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= RST_CTRL;
      mcfg_q <= RST_MCFG;
      mlvl_q <= RST_LVL;
      mslp_q <= RST_SLP;
      rslp_q <= RST_SLP;
      acfg_q <= RST_ACFG;
      rcfg_q <= RST_RCFG;
      for (int k = 0; k < 3; k++) rlvl_q[k] <= RST_LVL;
    end else if (srst_q) begin
      // soft reset kept synchronous so the async branch stays pure
      ctrl_q <= RST_CTRL;
      mcfg_q <= RST_MCFG;
      mlvl_q <= RST_LVL;
      mslp_q <= RST_SLP;
      rslp_q <= RST_SLP;
      acfg_q <= RST_ACFG;
      rcfg_q <= RST_RCFG;
      for (int k = 0; k < 3; k++) rlvl_q[k] <= RST_LVL;
    end else if (wr_en) begin
      case (idx)
        IDX_CTRL: ctrl_q <= {5'h0, PWDATA[2:1], 1'b0};
        IDX_MCFG: mcfg_q <= {PWDATA[7], 4'h0, PWDATA[2:0]};
        IDX_MLVL: mlvl_q <= PWDATA[7:0];
        IDX_MSLP: mslp_q <= PWDATA[7:0];
        IDX_RSLP: rslp_q <= PWDATA[7:0];
        IDX_ACFG: acfg_q <= {PWDATA[7:6], 4'h0, PWDATA[1:0]};
        IDX_RCFG: rcfg_q <= {PWDATA[7:4], 2'h0, PWDATA[1:0]};
        // level writes stay open while the gate input toggles
        IDX_RLVL0, IDX_RLVL1, IDX_RLVL2:
          rlvl_q[2'(idx - IDX_RLVL0)] <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // pin synchronisers
  logic indicator_gate_input_s1_q, indicator_gate_input_s2_q, duty_s1_q, duty_s2_q;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      indicator_gate_input_s1_q <= 1'b0;
      indicator_gate_input_s2_q <= 1'b0;
      duty_s1_q <= 1'b0;
      duty_s2_q <= 1'b0;
    end else begin
      indicator_gate_input_s1_q <= INDICATOR_GATE_INPUT_IN;
      indicator_gate_input_s2_q <= indicator_gate_input_s1_q;
      duty_s1_q <= DUTY_IN;
      duty_s2_q <= duty_s1_q;
    end
  end

  // no glitch filter: the far side guarantees a long enough active level
  logic indicator_gate_input_act;
  assign indicator_gate_input_act = indicator_gate_input_s2_q ^ rcfg_q.pol;

  // duty measurement: count active and idle time, divide, average
  logic act, act_d_q, sat;
  logic [19:0] hi_q, lo_q;
  logic [21:0] rem_q;
  logic [20:0] per_q;
  logic [7:0] quo_q;
  logic [3:0] div_q;
  logic smp_v;
  logic [7:0] smp;
  logic [21:0] rem2;
  assign act = ~(duty_s2_q ^ mcfg_q.pol);
  assign sat = act ? (hi_q == DUTY_CNT_MAX) : (lo_q == DUTY_CNT_MAX);
  assign rem2 = {rem_q[20:0], 1'b0};

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      // starts high so no false active edge follows reset
      act_d_q <= 1'b1;
      hi_q <= 20'h0;
      lo_q <= 20'h0;
    end else begin
      act_d_q <= act;
      if ((act && !act_d_q) || sat) begin
        hi_q <= {19'h0, act};
        lo_q <= {19'h0, !act};
      end else if (act) begin
        hi_q <= hi_q + 20'h1;
      end else begin
        lo_q <= lo_q + 20'h1;
      end
    end
  end

  // restoring divider gives active/period in 1/256 units
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rem_q <= 22'h0;
      per_q <= 21'h0;
      quo_q <= 8'h0;
      div_q <= 4'h0;
    end else if (div_q != 4'h0) begin
      div_q <= div_q - 4'h1;
      if (rem2 >= {1'b0, per_q}) begin
        rem_q <= rem2 - {1'b0, per_q};
        quo_q <= {quo_q[6:0], 1'b1};
      end else begin
        rem_q <= rem2;
        quo_q <= {quo_q[6:0], 1'b0};
      end
    end else if (act && !act_d_q && !sat) begin
      rem_q <= {2'h0, hi_q};
      per_q <= {1'b0, hi_q} + {1'b0, lo_q};
      quo_q <= 8'h0;
      div_q <= DIV_STEPS;
    end
  end

  // a stuck input yields 0 or 100 percent instead of a stale value
  always_comb begin
    smp_v = 1'b0;
    smp = quo_q;
    if (sat) begin
      smp_v = 1'b1;
      smp = act ? 8'hff : 8'h00;
    end else if (div_q == 4'h1) begin
      smp_v = 1'b1;
      smp = {quo_q[6:0], rem2 >= {1'b0, per_q}};
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) acc_q <= 10'h0;
    else if (smp_v) acc_q <= acc_q - {2'h0, acc_q[9:2]} + {2'h0, smp};
  end
  assign avg = acc_q[9:2];

  // settle hold, then run or hold the previous current
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_q <= C_OFF;
      set_cnt_q <= 20'h0;
      snap_q <= 9'h0;
    end else begin
      case (st_q)
        C_OFF: begin
          set_cnt_q <= 20'h0;
          snap_q <= v_q[3];
          if (mcfg_q.cai_en) st_q <= C_SET;
        end
        C_SET: begin
          set_cnt_q <= set_cnt_q + 20'h1;
          if (!mcfg_q.cai_en) st_q <= C_OFF;
          else if (set_cnt_q == 20'(SETTLE_N - 1))
            st_q <= (mcfg_q.mhd && !mcfg_q.comb) ? C_HOLD : C_RUN;
        end
        C_RUN, C_HOLD: if (!mcfg_q.cai_en) st_q <= C_OFF;
        default: st_q <= C_OFF;
      endcase
    end
  end

  // ambient path: 4-sample average, level conversion, timing
  logic [9:0] asum_q;
  logic [1:0] acnt_q;
  logic [3:0] lvl_conv;
  logic [26:0] mcnt_q;
  logic [26:0] mper;
  logic bias_q, start_q, key_q;

  always_comb begin
    lvl_conv = 4'h0;
    if (acfg_q.curve) begin
      lvl_conv = als_avg_q[7:4];
    end else begin
      for (int b = 1; b < 8; b++)
        if (als_avg_q[b]) lvl_conv = {3'(b), als_avg_q[b - 1]};
    end
  end

  logic [9:0] asum_d;
  assign asum_d = asum_q + {2'h0, ALS_DATA};
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      asum_q <= 10'h0;
      acnt_q <= 2'h0;
      als_avg_q <= 8'h0;
      als_lvl_q <= 4'h0;
    end else begin
      als_lvl_q <= lvl_conv;
      if (ALS_VALID) begin
        acnt_q <= acnt_q + 2'h1;
        if (acnt_q == 2'h3) begin
          als_avg_q <= asum_d[9:2];
          asum_q <= 10'h0;
        end else begin
          asum_q <= asum_d;
        end
      end
    end
  end

  assign mper = 27'(MEAS_BASE_N * (int'(acfg_q.per) + 1));
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mcnt_q <= 27'h0;
      bias_q <= 1'b0;
      start_q <= 1'b0;
      key_q <= 1'b0;
    end else begin
      if (!ctrl_q.alc_en || mcnt_q >= mper - 27'h1) mcnt_q <= 27'h0;
      else mcnt_q <= mcnt_q + 27'h1;
      bias_q <= ctrl_q.alc_en &&
                (!acfg_q.sync || mcnt_q < 27'(MEAS_WIN_N));
      start_q <= ctrl_q.alc_en && mcnt_q == 27'(MEAS_WIN_N - 1);
      key_q <= ctrl_q.kb_en && als_lvl_q < KEY_DARK_LVL;
    end
  end
  assign BIAS_EN = bias_q;
  assign ALS_START = start_q;
  assign KEYPAD_ON = key_q;

  // channel targets: 0 means off, n means level code n-1
  logic [8:0] base_v;
  logic [16:0] prod;
  assign base_v = ctrl_q.alc_en ? {1'b0, als_lvl_q, 4'hf} + 9'h1 :
                  mcfg_q.mhd ? {1'b0, mlvl_q} + 9'h1 : 9'h0;
  assign prod = base_v * avg;

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      tgt[c] = (rcfg_q.gate ? indicator_gate_input_act : rcfg_q.on[c]) ?
               {1'b0, rlvl_q[c]} + 9'h1 : 9'h0;
      ramp[c] = !rcfg_q.gate && rcfg_q.slope_en;
      rate[c] = rslp_q[6:0];
    end
    rate[3] = mslp_q[6:0];
    ramp[3] = 1'b0;
    case (st_q)
      C_OFF: begin
        tgt[3] = base_v;
        ramp[3] = mslp_q[7];
      end
      C_RUN: tgt[3] = mcfg_q.comb ? prod[16:8] :
                      {1'b0, avg};
      default: tgt[3] = snap_q;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pre_q <= 9'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= pre_q == 9'(SLOPE_UNIT_CYC - 1);
      pre_q <= (pre_q == 9'(SLOPE_UNIT_CYC - 1)) ? 9'h0 : pre_q + 9'h1;
    end
  end

  // one ramp engine per channel; channel 3 is the main white group
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic [6:0] cnt_q;
    logic step;
    logic [8:0] nv;
    assign step = tick_q && cnt_q >= rate[i];
    always_comb begin
      nv = v_q[i];
      if (!ramp[i]) nv = tgt[i];
      else if (step && v_q[i] < tgt[i]) nv = v_q[i] + 9'h1;
      else if (step && v_q[i] > tgt[i]) nv = v_q[i] - 9'h1;
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
        cnt_q <= 7'h0;
        v_q[i] <= 9'h0;
        en_q[i] <= 1'b0;
        lvl_q[i] <= 8'h0;
      end else begin
        if (step) cnt_q <= 7'h0;
        else if (tick_q) cnt_q <= cnt_q + 7'h1;
        v_q[i] <= nv;
        en_q[i] <= nv != 9'h0;
        lvl_q[i] <= nv[7:0] - 8'h1;
      end
    end
  end

  // sub group outputs come from channels 0 to 2, main outputs from channel 3
  assign RGB_EN = {en_q[2], en_q[1], en_q[0]};
  assign R_LVL = lvl_q[0];
  assign G_LVL = lvl_q[1];
  assign B_LVL = lvl_q[2];
  assign MAIN_EN = en_q[3];
  assign MAIN_LVL = lvl_q[3];

  gate_off_a: assert property (rcfg_q.gate && !indicator_gate_input_act |=> RGB_EN == 3'h0)
    else $error("colours lit while gate inactive");
  gate_on_a: assert property (rcfg_q.gate && indicator_gate_input_act |=> RGB_EN == 3'h7)
    else $error("gate active but colours not all on");
  host_on_a: assert property
    (!rcfg_q.gate && !rcfg_q.slope_en |=> RGB_EN == $past(rcfg_q.on))
    else $error("host on bits not followed");
  run_duty_a: assert property
    (st_q == C_RUN && !mcfg_q.comb |=> v_q[3] == {1'b0, $past(avg)})
    else $error("main current not duty derived");
  settle_hold_a: assert property
    (st_q == C_SET |=> v_q[3] == $past(snap_q))
    else $error("main current changed during settle");
  settle_len_a: assert property
    (st_q == C_SET && set_cnt_q < 20'(SETTLE_N - 1) |=>
     st_q == C_SET || st_q == C_OFF)
    else $error("settle ended early");
  rgb_slope_a: assert property
    (ramp[0] && $past(ramp[0]) |-> v_q[0] - $past(v_q[0]) <= 9'h1 ||
     $past(v_q[0]) - v_q[0] <= 9'h1)
    else $error("colour ramp jumped");
  bias_a: assert property
    (ctrl_q.alc_en && !acfg_q.sync ##1 ctrl_q.alc_en |-> BIAS_EN)
    else $error("bias off in continuous mode");
  bias_off_a: assert property (!ctrl_q.alc_en |=> !BIAS_EN)
    else $error("bias on without ambient enable");
  apb_err_a: assert property (PSEL && !PENABLE && !mapped |=> PSLVERR)
    else $error("unmapped access not flagged");

  run_c: cover property (st_q == C_SET ##1 st_q == C_RUN);
  hold_c: cover property (st_q == C_SET ##1 st_q == C_HOLD);
  gate_c: cover property (rcfg_q.gate && $rose(indicator_gate_input_act));
  alc_c: cover property (ctrl_q.alc_en && ALS_START);
endmodule
